// [core_ops_cfg.svh]
// Purpose: Reset values and fixed figures for the ALU, bit and skip executor
// Assumes: Included by its bare name wherever these constants are needed
// Notes: Definitions only
`ifndef CORE_OPS_CFG_SVH
`define CORE_OPS_CFG_SVH

// Working register and arithmetic flags after reset
`define ACC_RST 8'h00
`define FLAG_C_RST 1'b0
`define FLAG_HALF_RST 1'b0
`define FLAG_Z_RST 1'b0
// Active-low status bits rest high after reset
`define TIMEOUT_N_RST 1'b1
`define SLEEP_N_RST 1'b1
// Level written to both active-low bits by the watchdog kick
`define KICK_STATUS_LEVEL 1'b1
// Top bit of the low nibble, for the half carry
`define NIBBLE_MSB 3
// Cycles spent on the substituted no-op after a taken skip
`define SKIP_NOP_CYCLES 1

`endif

// [core_ops_pkg.sv]
// Purpose: Types shared by the executor and its neighbours
// Assumes: Encodings of the instruction word are resolved by the decoder upstream
// Notes: Operation codes are local to this block
package core_ops_pkg;

    // Operations this block executes; anything else is passed as a no-op
    typedef enum logic [3:0] {
        OP_NOP = 4'b0000,
        OP_ADD_IMMEDIATE_TO_ACC = 4'b0001,
        OP_ADD_ACC_AND_FILE = 4'b0010,
        OP_AND_IMMEDIATE_WITH_ACC = 4'b0011,
        OP_AND_ACC_WITH_FILE = 4'b0100,
        OP_BIT_CLEAR = 4'b0101,
        OP_BIT_SET = 4'b0110,
        OP_SKIP_IF_BIT_ZERO = 4'b0111,
        OP_SKIP_IF_BIT_ONE = 4'b1000,
        OP_WATCHDOG_KICK = 4'b1001
    } op_t;

    // Decoded instruction from the fetch unit
    typedef struct packed {
        logic valid;
        op_t op;
        logic [6:0] file_addr;
        logic dest_file;
        logic [2:0] bit_index;
        logic [7:0] immediate;
    } instr_t;

    // Write request to the register file
    typedef struct packed {
        logic we;
        logic [6:0] addr;
        logic [7:0] data;
    } file_wr_t;

    // Status bits this block owns
    typedef struct packed {
        logic carry;
        logic half_carry_flag;
        logic zero;
        logic timeout_status_n;
        logic sleep_status_n;
    } status_t;

endpackage

// [core_alu_bit_skip_ops.sv]
// Purpose: Executes add, and, bit set/clear, bit-test skip and watchdog kick
// Assumes: Register file read data arrives beside the instruction, same clock
// Notes: Results appear one clock after the instruction is presented
`timescale 1ns/1ps
`include "core_ops_cfg.svh"

module core_alu_bit_skip_ops
    import core_ops_pkg::*;
#(
    parameter int DATA_W = 8,
    parameter int ADDR_W = 7
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire instr_t INSTR,
    input wire logic [7:0] FILE_RDATA,
    input wire logic FILE_IS_IO,
    input wire logic [7:0] PIN_LEVELS,
    input wire logic TIMEOUT_EVENT,
    input wire logic SLEEP_EVENT,
    output file_wr_t FILE_WR,
    output logic [7:0] ACC,
    output status_t STATUS,
    output logic WATCHDOG_COUNT_CLR,
    output logic WATCHDOG_PRESC_CLR,
    output logic SKIP_TAKEN,
    output logic SKIP_PENDING
);

    // The datapath is built for one byte and a 7-bit file address only
    if (DATA_W != 8 || ADDR_W != 7) begin : g_width_check
        $error("core_alu_bit_skip_ops supports only DATA_W=8 and ADDR_W=7");
    end

    // Whole state of the block
    typedef struct packed {
        logic [7:0] acc;
        status_t stat;
        file_wr_t wr;
        logic kick_cnt_clr;
        logic kick_presc_clr;
        logic skip_pend;
        logic skip_taken;
        logic [7:0] pin_meta;
        logic [7:0] pin_sync;
    } state_t;

    state_t s_reg; // Registered state
    state_t s_next; // Next state
    logic [7:0] bit_mask; // One-hot of the bit index
    logic [7:0] operand; // File operand, pins for I/O registers
    logic [7:0] add_b; // Second addend
    logic [8:0] sum9; // Sum with carry out
    logic [4:0] half5; // Low nibble sum with half carry out
    logic [7:0] and_res; // AND result
    logic tested_bit; // Bit under test for skips
    logic exec; // Instruction really executes this cycle

    // One-hot mask, one decoder per bit
    for (genvar i = 0; i < 8; i++) begin : g_mask
        assign bit_mask[i] = (INSTR.bit_index == 3'(i));
    end

    // Pin levels stand in for the latch when an I/O register is read
    assign operand = FILE_IS_IO ? s_reg.pin_sync : FILE_RDATA;
    assign add_b = (INSTR.op == OP_ADD_IMMEDIATE_TO_ACC) ? INSTR.immediate : operand;
    // Carry and half carry come out of bits 7 and 3
    assign sum9 = {1'b0, s_reg.acc} + {1'b0, add_b};
    assign half5 = {1'b0, s_reg.acc[`NIBBLE_MSB:0]} + {1'b0, add_b[`NIBBLE_MSB:0]};
    assign and_res = s_reg.acc & ((INSTR.op == OP_AND_IMMEDIATE_WITH_ACC) ?
                                  INSTR.immediate : operand);
    assign tested_bit = |(operand & bit_mask);
    // An instruction that follows a taken skip is swallowed
    // Outside events still act while a skip is pending, only the instruction is lost
    assign exec = INSTR.valid && !s_reg.skip_pend;

    // Next-state logic
    always_comb begin
        s_next = s_reg;
        // Two-stage pin synchroniser; only the second stage is read
        s_next.pin_meta = PIN_LEVELS;
        s_next.pin_sync = s_reg.pin_meta;
        // Pulses default low
        s_next.wr.we = 1'b0;
        s_next.kick_cnt_clr = 1'b0;
        s_next.kick_presc_clr = 1'b0;
        s_next.skip_taken = 1'b0;
        s_next.wr.addr = INSTR.file_addr;
        // Outside events clear the active-low bits; a kick below wins
        if (TIMEOUT_EVENT) begin
            s_next.stat.timeout_status_n = 1'b0;
        end
        if (SLEEP_EVENT) begin
            s_next.stat.sleep_status_n = 1'b0;
        end
        if (s_reg.skip_pend) begin
            // Wait for the next instruction and run a no-op in its place
            if (INSTR.valid) begin
                s_next.skip_pend = 1'b0;
                s_next.skip_taken = 1'b1;
            end
        end else if (INSTR.valid) begin
            case (INSTR.op)
                OP_ADD_IMMEDIATE_TO_ACC: begin
                    s_next.acc = sum9[7:0];
                    s_next.stat.carry = sum9[8];
                    s_next.stat.half_carry_flag = half5[4];
                    s_next.stat.zero = (sum9[7:0] == 8'h00);
                end
                OP_ADD_ACC_AND_FILE: begin
                    // Destination bit picks file or accumulator
                    if (INSTR.dest_file) begin
                        s_next.wr.we = 1'b1;
                        s_next.wr.data = sum9[7:0];
                    end else begin
                        s_next.acc = sum9[7:0];
                    end
                    s_next.stat.carry = sum9[8];
                    s_next.stat.half_carry_flag = half5[4];
                    s_next.stat.zero = (sum9[7:0] == 8'h00);
                end
                OP_AND_IMMEDIATE_WITH_ACC: begin
                    s_next.acc = and_res;
                    s_next.stat.zero = (and_res == 8'h00);
                end
                OP_AND_ACC_WITH_FILE: begin
                    if (INSTR.dest_file) begin
                        s_next.wr.we = 1'b1;
                        s_next.wr.data = and_res;
                    end else begin
                        s_next.acc = and_res;
                    end
                    s_next.stat.zero = (and_res == 8'h00);
                end
                OP_BIT_CLEAR: begin
                    s_next.wr.we = 1'b1;
                    s_next.wr.data = operand & ~bit_mask;
                end
                OP_BIT_SET: begin
                    s_next.wr.we = 1'b1;
                    s_next.wr.data = operand | bit_mask;
                end
                OP_SKIP_IF_BIT_ZERO: begin
                    s_next.skip_pend = !tested_bit;
                end
                OP_SKIP_IF_BIT_ONE: begin
                    s_next.skip_pend = tested_bit;
                end
                OP_WATCHDOG_KICK: begin
                    s_next.kick_cnt_clr = 1'b1;
                    s_next.kick_presc_clr = 1'b1;
                    s_next.stat.timeout_status_n = `KICK_STATUS_LEVEL;
                    s_next.stat.sleep_status_n = `KICK_STATUS_LEVEL;
                end
                default: begin
                    // No-op and foreign codes change nothing
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            s_reg <= '0;
            s_reg.acc <= `ACC_RST;
            s_reg.stat.carry <= `FLAG_C_RST;
            s_reg.stat.half_carry_flag <= `FLAG_HALF_RST;
            s_reg.stat.zero <= `FLAG_Z_RST;
            s_reg.stat.timeout_status_n <= `TIMEOUT_N_RST;
            s_reg.stat.sleep_status_n <= `SLEEP_N_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the state register
    assign FILE_WR = s_reg.wr;
    assign ACC = s_reg.acc;
    assign STATUS = s_reg.stat;
    assign WATCHDOG_COUNT_CLR = s_reg.kick_cnt_clr;
    assign WATCHDOG_PRESC_CLR = s_reg.kick_presc_clr;
    assign SKIP_TAKEN = s_reg.skip_taken;
    assign SKIP_PENDING = s_reg.skip_pend;

    // Checks on the executed behaviour
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    AST_ADD_IMM_SUM: assert property (
        exec && INSTR.op == OP_ADD_IMMEDIATE_TO_ACC |=>
        ACC == 8'($past(s_reg.acc) + $past(INSTR.immediate)))
        else $error("add immediate sum wrong");

    AST_ADD_FILE_DEST: assert property (
        exec && INSTR.op == OP_ADD_ACC_AND_FILE && INSTR.dest_file |=>
        FILE_WR.we && ACC == $past(s_reg.acc) && FILE_WR.data == $past(sum9[7:0]))
        else $error("add to file went to the wrong place");

    AST_ADD_FILE_ACC: assert property (
        exec && INSTR.op == OP_ADD_ACC_AND_FILE && !INSTR.dest_file |=>
        !FILE_WR.we && ACC == 8'($past(s_reg.acc) + $past(operand)))
        else $error("add into accumulator wrong");

    AST_ADD_ZERO: assert property (
        exec && INSTR.op == OP_ADD_IMMEDIATE_TO_ACC |=>
        STATUS.zero == (ACC == 8'h00) && !FILE_WR.we)
        else $error("add immediate zero flag wrong");

    AST_AND_IMM_FLAGS: assert property (
        exec && INSTR.op == OP_AND_IMMEDIATE_WITH_ACC |=>
        $stable(STATUS.carry) && $stable(STATUS.half_carry_flag) && STATUS.zero == (ACC == 8'h00))
        else $error("and immediate touched the wrong flags");

    AST_AND_FILE_ACC: assert property (
        exec && INSTR.op == OP_AND_ACC_WITH_FILE && !INSTR.dest_file |=>
        !FILE_WR.we && ACC == ($past(s_reg.acc) & $past(operand)))
        else $error("and with file into accumulator wrong");

    AST_AND_FILE_DEST: assert property (
        exec && INSTR.op == OP_AND_ACC_WITH_FILE && INSTR.dest_file |=>
        FILE_WR.we && FILE_WR.addr == $past(INSTR.file_addr) && $stable(ACC)
        && FILE_WR.data == ($past(s_reg.acc) & $past(operand)) && $stable(STATUS.carry))
        else $error("and with file into file wrong");

    AST_BIT_CLEAR: assert property (
        exec && INSTR.op == OP_BIT_CLEAR |=>
        FILE_WR.we && FILE_WR.data == ($past(operand) & ~$past(bit_mask)) && $stable(ACC)
        && $stable(STATUS.carry) && $stable(STATUS.zero))
        else $error("bit clear wrong");

    AST_BIT_SET: assert property (
        exec && INSTR.op == OP_BIT_SET |=>
        FILE_WR.we && FILE_WR.data == ($past(operand) | $past(bit_mask))
        && $stable(STATUS.half_carry_flag) && $stable(STATUS.zero))
        else $error("bit set wrong");

    AST_SKIP_ZERO: assert property (
        exec && INSTR.op == OP_SKIP_IF_BIT_ZERO |=> SKIP_PENDING == !$past(tested_bit))
        else $error("skip on zero decided wrongly");

    AST_SKIP_ONE: assert property (
        exec && INSTR.op == OP_SKIP_IF_BIT_ONE |=> SKIP_PENDING == $past(tested_bit))
        else $error("skip on one decided wrongly");

    // Only arithmetic flags are frozen; outside events may still drop the active-low bits
    AST_SKIP_NOP: assert property (
        s_reg.skip_pend && INSTR.valid |=>
        SKIP_TAKEN && !SKIP_PENDING && !FILE_WR.we && $stable(ACC) && $stable(STATUS.carry)
        && $stable(STATUS.half_carry_flag) && $stable(STATUS.zero))
        else $error("swallowed instruction had an effect");

    AST_KICK_CLEAR: assert property (
        exec && INSTR.op == OP_WATCHDOG_KICK |=> WATCHDOG_COUNT_CLR && WATCHDOG_PRESC_CLR)
        else $error("watchdog kick did not clear counter and prescaler");

    AST_KICK_FLAGS: assert property (
        exec && INSTR.op == OP_WATCHDOG_KICK |=>
        !FILE_WR.we && $stable(ACC) && $stable(STATUS.zero) && $stable(STATUS.carry))
        else $error("watchdog kick touched the datapath");

    // Without a kick in the same cycle the timeout event drops its bit
    AST_EVENT_CLEARS: assert property (
        TIMEOUT_EVENT && !(exec && INSTR.op == OP_WATCHDOG_KICK) |=>
        !STATUS.timeout_status_n)
        else $error("timeout event did not clear its status bit");

    AST_KICK_STATUS: assert property (
        exec && INSTR.op == OP_WATCHDOG_KICK |=>
        STATUS.timeout_status_n && STATUS.sleep_status_n)
        else $error("watchdog kick did not set status bits");

    AST_IO_PINS: assert property (
        exec && INSTR.op == OP_BIT_SET && FILE_IS_IO |=>
        FILE_WR.data == ($past(s_reg.pin_sync) | $past(bit_mask)))
        else $error("I/O update did not use pin levels");

    AST_ADD_CARRY: assert property (
        exec && INSTR.op == OP_ADD_IMMEDIATE_TO_ACC |=>
        STATUS.carry == $past(sum9[8]) && STATUS.half_carry_flag == $past(half5[4]))
        else $error("add carries wrong");

    COV_ADD_CARRY: cover property (
        exec && INSTR.op == OP_ADD_ACC_AND_FILE && sum9[8]);
    COV_SKIP_TAKEN: cover property (
        exec && INSTR.op == OP_SKIP_IF_BIT_ONE && tested_bit ##1 INSTR.valid ##1 SKIP_TAKEN);
    COV_KICK: cover property (exec && INSTR.op == OP_WATCHDOG_KICK && TIMEOUT_EVENT);
    COV_IO_RMW: cover property (exec && INSTR.op == OP_BIT_CLEAR && FILE_IS_IO);
    // AND result written back to the file
    COV_AND_FILE_DEST: cover property (
        exec && INSTR.op == OP_AND_ACC_WITH_FILE && INSTR.dest_file ##1 FILE_WR.we);

endmodule

// [file_store_model.sv]
// Purpose: Register file beside the executor, with same-cycle read of the addressed byte
// Assumes: One write port fed by the executor, one read port addressed by the instruction
// Notes: A write on its way is forwarded so a dependent instruction sees the new byte
`timescale 1ns/1ps

module file_store_model
    import core_ops_pkg::*;
(
    input wire logic clk,
    input wire file_wr_t wr,
    input wire logic [6:0] rd_addr,
    output logic [7:0] rd_data
);
    // Storage, seeded with a known pattern the bench mirrors
    logic [7:0] mem [0:127];

    // Pattern fill at time zero
    initial begin
        for (int i = 0; i < 128; i++) begin
            mem[i] = 8'(i * 37);
        end
    end

    // Write lands at the end of the cycle that carries it
    always @(posedge clk) begin
        if (wr.we) begin
            mem[wr.addr] <= wr.data;
        end
    end

    // Forwarding, because the executor itself does none
    assign rd_data = (wr.we && wr.addr == rd_addr) ? wr.data : mem[rd_addr];
endmodule

// [core_alu_bit_skip_ops_tb_top.sv]
// Purpose: Self-checking bench for the executor, directed corners then random stream
// Assumes: Results one clock after each taken instruction
// Notes: Pins only used as operands once they have been stable for four edges
`timescale 1ns/1ps

module core_alu_bit_skip_ops_tb_top;
    import core_ops_pkg::*;
    logic CLK = 1'b0;
    logic RST_N = 1'b0;
    instr_t INSTR = '0;
    logic [7:0] FILE_RDATA;
    logic FILE_IS_IO = 1'b0;
    logic [7:0] PIN_LEVELS = 8'h00;
    logic TIMEOUT_EVENT = 1'b0;
    logic SLEEP_EVENT = 1'b0;
    file_wr_t FILE_WR;
    logic [7:0] ACC;
    status_t STATUS;
    logic WATCHDOG_COUNT_CLR, WATCHDOG_PRESC_CLR, SKIP_TAKEN, SKIP_PENDING;
    // Bench model state, starting at reset values
    logic [7:0] bm [0:127];
    logic [7:0] e_acc = 8'h00;
    status_t e_st = 5'b00011;
    file_wr_t e_wr = '0;
    logic e_wclr = 1'b0, e_skt = 1'b0, e_skp = 1'b0;
    int fail_count = 0, checked = 0, cycles = 0;

    always #10 CLK = ~CLK;

    core_alu_bit_skip_ops DUT (.CLK(CLK), .RST_N(RST_N), .INSTR(INSTR),
        .FILE_RDATA(FILE_RDATA), .FILE_IS_IO(FILE_IS_IO), .PIN_LEVELS(PIN_LEVELS),
        .TIMEOUT_EVENT(TIMEOUT_EVENT), .SLEEP_EVENT(SLEEP_EVENT), .FILE_WR(FILE_WR),
        .ACC(ACC), .STATUS(STATUS), .WATCHDOG_COUNT_CLR(WATCHDOG_COUNT_CLR),
        .WATCHDOG_PRESC_CLR(WATCHDOG_PRESC_CLR), .SKIP_TAKEN(SKIP_TAKEN),
        .SKIP_PENDING(SKIP_PENDING));
    file_store_model partner (.clk(CLK), .wr(FILE_WR), .rd_addr(INSTR.file_addr),
        .rd_data(FILE_RDATA));

    // Result goes to file or accumulator
    task automatic store(input logic [7:0] r, input logic to_file);
        if (to_file) begin
            e_wr = '{1'b1, INSTR.file_addr, r};
            bm[INSTR.file_addr] = r;
        end else begin
            e_acc = r;
        end
    endtask

    // Expected effect of the inputs seen at this edge
    task automatic step();
        logic [7:0] opnd, k, r;
        logic [8:0] s;
        opnd = FILE_IS_IO ? PIN_LEVELS : bm[INSTR.file_addr];
        k = (INSTR.op == OP_ADD_IMMEDIATE_TO_ACC || INSTR.op == OP_AND_IMMEDIATE_WITH_ACC) ?
            INSTR.immediate : opnd;
        s = {1'b0, e_acc} + {1'b0, k};
        r = opnd;
        e_wr.we = 1'b0;
        e_wclr = 1'b0;
        e_skt = 1'b0;
        if (TIMEOUT_EVENT) e_st.timeout_status_n = 1'b0;
        if (SLEEP_EVENT) e_st.sleep_status_n = 1'b0;
        if (INSTR.valid && e_skp) begin
            e_skp = 1'b0;
            e_skt = 1'b1;
        end else if (INSTR.valid) begin
            case (INSTR.op)
                OP_ADD_IMMEDIATE_TO_ACC, OP_ADD_ACC_AND_FILE: begin
                    e_st.carry = s[8];
                    e_st.half_carry_flag = (5'(e_acc[3:0]) + 5'(k[3:0])) > 5'h0F;
                    e_st.zero = (s[7:0] == 8'h00);
                    store(s[7:0], INSTR.op == OP_ADD_ACC_AND_FILE && INSTR.dest_file);
                end
                OP_AND_IMMEDIATE_WITH_ACC, OP_AND_ACC_WITH_FILE: begin
                    e_st.zero = ((e_acc & k) == 8'h00);
                    store(e_acc & k, INSTR.op == OP_AND_ACC_WITH_FILE && INSTR.dest_file);
                end
                OP_BIT_CLEAR: begin
                    r[INSTR.bit_index] = 1'b0;
                    store(r, 1'b1);
                end
                OP_BIT_SET: begin
                    r[INSTR.bit_index] = 1'b1;
                    store(r, 1'b1);
                end
                OP_SKIP_IF_BIT_ZERO: e_skp = ~opnd[INSTR.bit_index];
                OP_SKIP_IF_BIT_ONE: e_skp = opnd[INSTR.bit_index];
                OP_WATCHDOG_KICK: begin
                    e_wclr = 1'b1;
                    e_st.timeout_status_n = 1'b1;
                    e_st.sleep_status_n = 1'b1;
                end
                default: ;
            endcase
        end
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Predict at each edge, with a ceiling on the run
    always @(posedge CLK) begin
        if (RST_N) step();
        cycles++;
        if (cycles > 5000) begin
            fail_count++;
            wrap_up();
        end
    end

    // Outputs have settled by the falling edge
    always @(negedge CLK) begin
        check(16'(ACC), 16'(e_acc));
        check(16'(STATUS[4:2]), 16'(e_st[4:2]));
        check(16'(STATUS[1:0]), 16'(e_st[1:0]));
        check(16'(WATCHDOG_COUNT_CLR), 16'(e_wclr));
        check(16'(WATCHDOG_PRESC_CLR), 16'(e_wclr));
        check(16'(SKIP_TAKEN), 16'(e_skt));
        check(16'(SKIP_PENDING), 16'(e_skp));
        check(16'(FILE_WR.we), 16'(e_wr.we));
        if (e_wr.we) check({1'b0, FILE_WR.addr, FILE_WR.data}, {1'b0, e_wr.addr, e_wr.data});
    end

    task automatic issue(input op_t op, input logic [6:0] a, input logic d,
        input logic [2:0] b, input logic [7:0] k);
        INSTR <= '{1'b1, op, a, d, b, k};
        @(posedge CLK);
    endtask

    // Corners first, then the random stream
    initial begin
        for (int i = 0; i < 128; i++) bm[i] = 8'(i * 37);
        void'($urandom(21633));
        repeat (16) @(posedge CLK);
        RST_N <= 1'b1;
        @(posedge CLK);
        issue(OP_ADD_IMMEDIATE_TO_ACC, 7'h00, 1'b0, 3'h0, 8'hFF);
        issue(OP_ADD_IMMEDIATE_TO_ACC, 7'h00, 1'b0, 3'h0, 8'h01);
        issue(OP_SKIP_IF_BIT_ONE, 7'h01, 1'b0, 3'h0, 8'h00);
        INSTR.valid <= 1'b0;
        @(posedge CLK);
        issue(OP_WATCHDOG_KICK, 7'h00, 1'b0, 3'h0, 8'h00);
        issue(OP_WATCHDOG_KICK, 7'h00, 1'b0, 3'h0, 8'h00);
        issue(OP_SKIP_IF_BIT_ZERO, 7'h01, 1'b0, 3'h1, 8'h00);
        issue(OP_BIT_SET, 7'h01, 1'b1, 3'h7, 8'h00);
        issue(OP_BIT_CLEAR, 7'h01, 1'b0, 3'h0, 8'h00);
        issue(OP_SKIP_IF_BIT_ONE, 7'h01, 1'b0, 3'h0, 8'h00);
        issue(OP_ADD_ACC_AND_FILE, 7'h01, 1'b1, 3'h0, 8'h00);
        for (int i = 0; i < 3000; i++) begin
            if (i % 16 == 0) PIN_LEVELS <= 8'($urandom);
            FILE_IS_IO <= (i % 16 >= 4) && ($urandom_range(0, 3) == 0);
            TIMEOUT_EVENT <= ($urandom_range(0, 15) == 0);
            SLEEP_EVENT <= ($urandom_range(0, 15) == 0);
            INSTR <= '{($urandom_range(0, 7) != 0), op_t'(4'($urandom_range(0, 11))),
                7'($urandom_range(0, 7)), 1'($urandom), 3'($urandom), 8'($urandom)};
            @(posedge CLK);
        end
        INSTR.valid <= 1'b0;
        repeat (2) @(posedge CLK);
        wrap_up();
    end
endmodule
